/* File: ses_pkg.sv */
// shared constants and types for the status event summary block
package ses_pkg;
  localparam int SES_W    = 16;          // status register width
  localparam int SES_NSET = 4;           // register sets
  localparam int SES_QCW  = 5;           // queue count width
  // register set indices
  localparam logic [1:0] SET_STD  = 2'h0;
  localparam logic [1:0] SET_OPER = 2'h1;
  localparam logic [1:0] SET_MEAS = 2'h2;
  localparam logic [1:0] SET_QUES = 2'h3;
  // status byte bit positions
  localparam int SB_MEAS   = 0;
  localparam int SB_ERRQ   = 2;        // error queue holds messages
  localparam int SB_QUES   = 3;
  localparam int SB_MAV    = 4;        // output queue holds responses
  localparam int SB_STD    = 5;
  localparam int SB_MASTER = 6;        // master summary or request flag
  localparam int SB_OPER   = 7;
  localparam logic [7:0] SB_SUM_MASK = 8'hBD;  // bits 0,2,3,4,5,7
  // queue depth and steps
  localparam logic [SES_QCW-1:0] QCNT_FULL = 5'h10;
  localparam logic [SES_QCW-1:0] QCNT_ONE  = 5'h01;
  // ascii codes for number parsing and headers
  localparam logic [7:0] ASC_HASH  = 8'h23;
  localparam logic [7:0] ASC_0     = 8'h30;
  localparam logic [7:0] ASC_9     = 8'h39;
  localparam logic [7:0] ASC_LOWER = 8'h20;
  localparam logic [7:0] ASC_LA    = 8'h61;
  localparam logic [7:0] ASC_LF    = 8'h66;
  localparam logic [7:0] ASC_LB    = 8'h62;
  localparam logic [7:0] ASC_LH    = 8'h68;
  localparam logic [7:0] ASC_LQ    = 8'h71;
  localparam logic [7:0] HDR_NONE  = 8'h00;
  localparam logic [7:0] HDR_B     = 8'h42;
  localparam logic [7:0] HDR_H     = 8'h48;
  localparam logic [7:0] HDR_Q     = 8'h51;
  localparam logic [4:0] RAD_BIN   = 5'h02;
  localparam logic [4:0] RAD_OCT   = 5'h08;
  localparam logic [4:0] RAD_DEC   = 5'h0A;
  localparam logic [4:0] RAD_HEX   = 5'h10;
  localparam logic [4:0] DIG_NONE  = 5'h1F;
  // commands delivered by the message link decoder
  typedef enum logic [3:0] {
    OP_CLS = 4'h0, OP_STAT_PRE = 4'h1, OP_QUE_CLR = 4'h2,
    OP_ERR_CLR = 4'h3, OP_SYS_PRE = 4'h4, OP_RST = 4'h5,
    OP_WR_EN = 4'h6, OP_QUERY = 4'h7, OP_FMT = 4'h8
  } ses_op_t;
  typedef enum logic [2:0] {
    REG_COND = 3'h0, REG_EVT = 3'h1, REG_EN = 3'h2,
    REG_STB = 3'h3, REG_SRE = 3'h4
  } ses_reg_t;
  typedef enum logic [1:0] {
    FMT_ASC = 2'h0, FMT_HEX = 2'h1, FMT_OCT = 2'h2, FMT_BIN = 2'h3
  } ses_fmt_t;
endpackage : ses_pkg

/* File: ses_num_if.sv */
// carrier between the status block and its parameter parser
`timescale 1ns/1ns
interface ses_num_if;
  logic                       chr_vld;
  logic [7:0]                 chr;
  logic                       clr;
  logic [ses_pkg::SES_W-1:0]  val;
  logic                       ok;
  modport host   (output chr_vld, chr, clr, input val, ok);
  modport parser (input chr_vld, chr, clr, output val, ok);
endinterface : ses_num_if

/* File: ses_num_parse.sv */
// parser for decimal and headed binary/hex/octal enable values
`timescale 1ns/1ns
module ses_num_parse (
  input  wire logic   clk_sys_i,  // system clock
  input  wire logic   rst_n_i,    // sync reset, active low
  ses_num_if.parser   np          // character stream and value
);
  import ses_pkg::*;

  typedef enum logic [2:0] {
    P_IDLE = 3'h1, P_HASH = 3'h2, P_DIG = 3'h4
  } ses_pst_t;

  typedef struct packed {
    ses_pst_t          st;
    logic [4:0]        radix;
    logic [SES_W-1:0]  val;
    logic              seen;
    logic              bad;
  } ses_pq_t;

  ses_pq_t q, n;

  // digit value of a character, DIG_NONE when not a digit
  function automatic logic [4:0] dval(input logic [7:0] c);
    logic [7:0] lc;
    lc = c | ASC_LOWER;
    if (c >= ASC_0 && c <= ASC_9) return 5'(c - ASC_0);
    if (lc >= ASC_LA && lc <= ASC_LF) return 5'(lc - ASC_LA + RAD_DEC);
    return DIG_NONE;
  endfunction : dval

  // header letter accepted in either case; digit checked per radix
  always_comb begin
    logic [4:0] d;
    logic       take;
    logic [7:0] lc;
    d    = dval(np.chr);
    take = 1'b0;
    lc   = np.chr | ASC_LOWER;
    n    = q;
    if (np.clr) begin
      n = '{st: P_IDLE, radix: RAD_DEC, default: '0};
    end else if (np.chr_vld) begin
      unique case (q.st)
        P_IDLE: begin
          if (np.chr == ASC_HASH) begin
            n.st = P_HASH;
          end else begin
            n.radix = RAD_DEC;                    // no header: decimal
            n.st    = P_DIG;
            take    = 1'b1;
          end
        end
        P_HASH: begin
          n.st = P_DIG;
          if (lc == ASC_LB) n.radix = RAD_BIN;
          else if (lc == ASC_LH) n.radix = RAD_HEX;
          else if (lc == ASC_LQ) n.radix = RAD_OCT;
          else n.bad = 1'b1;
        end
        P_DIG: take = 1'b1;
      endcase
      if (take) begin
        // digit outside the radix spoils the value
        if (d < n.radix) begin
          n.val  = 16'(q.val * 16'(n.radix) + 16'(d));
          n.seen = 1'b1;
        end else begin
          n.bad = 1'b1;
        end
      end
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) q <= '{st: P_IDLE, radix: RAD_DEC, default: '0};
    else q <= n;
  end

  assign np.val = q.val;
  assign np.ok  = q.seen & ~q.bad;
endmodule : ses_num_parse

/* File: status_event_summary.sv */
// status registers, queues, status byte and service request logic
`timescale 1ns/1ns
module status_event_summary (
  input  wire logic                     clk_sys_i,   // 100 MHz clock
  input  wire logic                     rst_n_i,     // sync reset, low
  input  wire logic [ses_pkg::SES_NSET-1:0][ses_pkg::SES_W-1:0]
                                        cond_i,      // present state
  input  wire logic [ses_pkg::SES_NSET-1:0][ses_pkg::SES_W-1:0]
                                        evt_i,       // event pulses
  input  wire logic                     cmd_vld_i,   // command strobe
  input  wire ses_pkg::ses_op_t         cmd_op_i,    // command code
  input  wire ses_pkg::ses_reg_t        cmd_reg_i,   // register kind
  input  wire logic [1:0]               cmd_set_i,   // register set
  input  wire ses_pkg::ses_fmt_t        cmd_fmt_i,   // readback format
  input  wire logic                     par_clr_i,   // new parameter
  input  wire logic                     par_vld_i,   // parameter char
  input  wire logic [7:0]               par_chr_i,   // ascii character
  input  wire logic                     err_push_i,  // error message
  input  wire logic                     err_pop_i,   // error read out
  input  wire logic                     oq_pop_i,    // response sent
  input  wire logic                     spoll_i,     // serial poll
  output logic [7:0]                    stb_o,       // status byte
  output logic [7:0]                    spoll_o,     // poll byte
  output logic                          spoll_vld_o, // poll byte valid
  output logic                          srq_o,       // service request
  output logic                          rsp_vld_o,   // query answer
  output logic [ses_pkg::SES_W-1:0]     rsp_val_o,   // answer value
  output logic [7:0]                    rsp_hdr_o,   // header letter
  output ses_pkg::ses_fmt_t             rsp_fmt_o,   // answer format
  output logic                          wr_err_o     // write refused
);
  import ses_pkg::*;

  typedef struct packed {
    logic [SES_NSET-1:0][SES_W-1:0] cond;
    logic [SES_NSET-1:0][SES_W-1:0] evt;
    logic [SES_NSET-1:0][SES_W-1:0] en;
    logic [7:0]                     sre;
    logic [SES_QCW-1:0]             oq_cnt;
    logic [SES_QCW-1:0]             eq_cnt;
    logic [7:0]                     stb;
    logic                           request_for_service_flag;
    logic [7:0]                     spoll;
    logic                           spoll_vld;
    ses_fmt_t                       fmt;
    logic                           rsp_vld;
    logic [SES_W-1:0]               rsp_val;
    logic [7:0]                     rsp_hdr;
    ses_fmt_t                       rsp_fmt;
    logic                           wr_err;
  } ses_st_t;

  ses_st_t q, n;
  ses_num_if np ();

  // parameter characters come from same-clock decoder logic
  assign np.chr_vld = par_vld_i;
  assign np.chr     = par_chr_i;
  assign np.clr     = par_clr_i;

  ses_num_parse u_parse (
    .clk_sys_i (clk_sys_i),
    .rst_n_i   (rst_n_i),
    .np        (np)
  );

  // saturating counter step; pop of an empty queue is ignored
  function automatic logic [SES_QCW-1:0] qstep(
    input logic [SES_QCW-1:0] c,
    input logic               push,
    input logic               pop
  );
    logic [SES_QCW-1:0] r;
    r = c;
    if (push && !pop && c != QCNT_FULL) r = SES_QCW'(c + QCNT_ONE);
    if (pop && !push && c != '0) r = SES_QCW'(c - QCNT_ONE);
    return r;
  endfunction : qstep

  logic             eq_clr, err_new, oq_push, req_rise;
  logic [7:0]       en_sum_now, en_sum_old;
  logic [SES_W-1:0] sel_evt, sel_en, sel_cond;

  // register set picked by the command
  assign sel_evt  = q.evt[cmd_set_i];
  assign sel_en   = q.en[cmd_set_i];
  assign sel_cond = q.cond[cmd_set_i];

  // command decode, latching, queues and status byte
  always_comb begin
    n           = q;
    eq_clr      = 1'b0;
    err_new     = 1'b0;
    oq_push     = 1'b0;
    n.rsp_vld   = 1'b0;
    n.wr_err    = 1'b0;
    n.spoll_vld = 1'b0;
    n.cond      = cond_i;
    if (cmd_vld_i) begin
      unique case (cmd_op_i)
        OP_CLS: begin
          n.evt          = '0;
          n.en[SET_OPER] = '0;
          n.en[SET_MEAS] = '0;
          n.en[SET_QUES] = '0;                    // standard kept
          eq_clr         = 1'b1;
        end
        OP_STAT_PRE: begin
          // error queue and standard enable untouched
          n.en[SET_OPER] = '0;
          n.en[SET_MEAS] = '0;
          n.en[SET_QUES] = '0;
        end
        OP_QUE_CLR, OP_ERR_CLR: eq_clr = 1'b1;
        OP_SYS_PRE, OP_RST: ;                     // no effect
        OP_WR_EN: begin
          // a spoiled value or a read-only target is an error
          if (!np.ok) begin
            err_new  = 1'b1;
            n.wr_err = 1'b1;
          end else if (cmd_reg_i == REG_EN) begin
            n.en[cmd_set_i] = np.val;             // zero clears
          end else if (cmd_reg_i == REG_SRE) begin
            n.sre = np.val[7:0];
          end else begin
            err_new  = 1'b1;                      // read-only
            n.wr_err = 1'b1;
          end
        end
        OP_QUERY: begin
          n.rsp_vld = 1'b1;
          oq_push   = 1'b1;
          n.rsp_fmt = q.fmt;
          unique case (cmd_reg_i)
            REG_COND: n.rsp_val = sel_cond;
            REG_EVT: begin
              n.rsp_val        = sel_evt;
              n.evt[cmd_set_i] = '0;              // read clears
            end
            REG_EN:  n.rsp_val = sel_en;
            REG_STB: n.rsp_val = SES_W'(q.stb);   // bit 6 is master
            REG_SRE: n.rsp_val = SES_W'(q.sre);
            default: n.rsp_val = '0;
          endcase
          unique case (q.fmt)
            FMT_HEX: n.rsp_hdr = HDR_H;
            FMT_OCT: n.rsp_hdr = HDR_Q;
            FMT_BIN: n.rsp_hdr = HDR_B;
            FMT_ASC: n.rsp_hdr = HDR_NONE;        // decimal, no header
          endcase
        end
        OP_FMT: n.fmt = cmd_fmt_i;
        default: ;
      endcase
    end
    // new events win over any clear in the same cycle
    n.evt = n.evt | evt_i;
    // error queue: clear first so a same-cycle push survives
    if (eq_clr) n.eq_cnt = '0;
    n.eq_cnt = qstep(n.eq_cnt, err_push_i | err_new, err_pop_i);
    n.oq_cnt = qstep(q.oq_cnt, oq_push, oq_pop_i);
    // status byte follows its sources, never latches
    n.stb            = '0;
    n.stb[SB_MEAS]   = |(n.evt[SET_MEAS] & n.en[SET_MEAS]);
    n.stb[SB_ERRQ]   = (n.eq_cnt != '0);
    n.stb[SB_QUES]   = |(n.evt[SET_QUES] & n.en[SET_QUES]);
    n.stb[SB_MAV]    = (n.oq_cnt != '0);
    n.stb[SB_STD]    = |(n.evt[SET_STD] & n.en[SET_STD]);
    n.stb[SB_OPER]   = |(n.evt[SET_OPER] & n.en[SET_OPER]);
    en_sum_now       = n.stb & n.sre & SB_SUM_MASK;
    en_sum_old       = q.stb & q.sre & SB_SUM_MASK;
    n.stb[SB_MASTER] = |en_sum_now;
    // any enabled summary going 0 to 1 requests service
    req_rise = |(en_sum_now & ~en_sum_old);
    // poll returns the request flag and clears it; a rise wins
    if (spoll_i) begin
      n.spoll            = q.stb;
      n.spoll[SB_MASTER] = q.request_for_service_flag;
      n.spoll_vld        = 1'b1;
    end
    n.request_for_service_flag = req_rise |
      (q.request_for_service_flag & ~spoll_i);
  end

  // single state register; power-up clears all of it
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) q <= '0;
    else q <= n;
  end

  assign stb_o       = q.stb;
  assign spoll_o     = q.spoll;
  assign spoll_vld_o = q.spoll_vld;
  assign srq_o       = q.request_for_service_flag;
  assign rsp_vld_o   = q.rsp_vld;
  assign rsp_val_o   = q.rsp_val;
  assign rsp_hdr_o   = q.rsp_hdr;
  assign rsp_fmt_o   = q.rsp_fmt;
  assign wr_err_o    = q.wr_err;

  // checks, all on the system clock
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rst_n_i);

  logic quiet;
  assign quiet = (evt_i == '0) && !err_push_i && !err_pop_i && !oq_pop_i;

  a_evt_latch: assert property (
    (evt_i[SET_OPER] != '0) |=>
      ((q.evt[SET_OPER] & $past(evt_i[SET_OPER])) ==
       $past(evt_i[SET_OPER])))
    else $error("event pulse not latched");

  a_cond_follow: assert property (
    1'b1 |=> q.cond == $past(cond_i))
    else $error("condition register stale");

  a_sum_bits: assert property (
    q.stb[SB_STD] == |(q.evt[SET_STD] & q.en[SET_STD]) &&
    q.stb[SB_OPER] == |(q.evt[SET_OPER] & q.en[SET_OPER]))
    else $error("set summary mismatch");

  a_master_sum: assert property (
    q.stb[SB_MASTER] == |(q.stb & q.sre & SB_SUM_MASK))
    else $error("master summary wrong");

  a_queue_sum: assert property (
    q.stb[SB_ERRQ] == (q.eq_cnt != '0) &&
    q.stb[SB_MAV] == (q.oq_cnt != '0))
    else $error("queue summary wrong");

  a_power_up: assert property (
    disable iff (1'b0) !rst_n_i |=> (q == '0))
    else $error("state not cleared by reset");

  a_cls_clear: assert property (
    cmd_vld_i && cmd_op_i == OP_CLS && quiet |=>
      q.evt == '0 && q.eq_cnt == '0 && q.en[SET_QUES] == '0)
    else $error("clear status incomplete");

  a_std_en_keep: assert property (
    cmd_vld_i && (cmd_op_i == OP_CLS || cmd_op_i == OP_STAT_PRE) |=>
      $stable(q.en[SET_STD]))
    else $error("standard enable disturbed");

  a_preset_none: assert property (
    cmd_vld_i && (cmd_op_i == OP_SYS_PRE || cmd_op_i == OP_RST) && quiet
      |=> $stable(q.evt) && $stable(q.en) && $stable(q.eq_cnt) &&
          $stable(q.oq_cnt) && $stable(q.sre))
    else $error("preset touched status");

  a_stat_pre_eq: assert property (
    cmd_vld_i && cmd_op_i == OP_STAT_PRE && quiet |=> $stable(q.eq_cnt))
    else $error("status preset changed error queue");

  a_req_rise: assert property (
    !q.stb[SB_MASTER] ##1 q.stb[SB_MASTER] |-> q.request_for_service_flag)
    else $error("no service request on rise");

  a_poll_clear: assert property (
    spoll_i && q.request_for_service_flag |=> spoll_vld_o &&
      spoll_o[SB_MASTER] &&
      (q.request_for_service_flag ==
       ((q.stb & q.sre & SB_SUM_MASK &
         ~$past(q.stb & q.sre & SB_SUM_MASK)) != '0)))
    else $error("poll did not clear request");

  a_qry_clear: assert property (
    cmd_vld_i && cmd_op_i == OP_QUERY && cmd_reg_i == REG_EVT &&
      evt_i == '0 |=> q.rsp_val == $past(sel_evt) &&
      q.evt[$past(cmd_set_i)] == '0 && rsp_vld_o)
    else $error("event query did not clear");

  a_hdr_fmt: assert property (
    rsp_vld_o |-> (rsp_fmt_o == FMT_ASC) == (rsp_hdr_o == HDR_NONE))
    else $error("header does not match format");

  // writes, queue entries and the readback format
  a_wr_refuse: assert property (
    cmd_vld_i && cmd_op_i == OP_WR_EN &&
      cmd_reg_i inside {REG_COND, REG_EVT, REG_STB} |=> wr_err_o)
    else $error("read-only write not refused");

  a_en_write: assert property (
    cmd_vld_i && cmd_op_i == OP_WR_EN && cmd_reg_i == REG_EN && np.ok
      |=> q.en[$past(cmd_set_i)] == $past(np.val))
    else $error("enable write lost");

  a_sre_write: assert property (
    cmd_vld_i && cmd_op_i == OP_WR_EN && cmd_reg_i == REG_SRE && np.ok
      |=> q.sre == $past(np.val[7:0]))
    else $error("request enable write lost");

  a_oq_push: assert property (
    cmd_vld_i && cmd_op_i == OP_QUERY && !oq_pop_i &&
      q.oq_cnt != QCNT_FULL |=>
      q.oq_cnt == SES_QCW'($past(q.oq_cnt) + QCNT_ONE))
    else $error("query answer not queued");

  a_err_push: assert property (
    cmd_vld_i && cmd_op_i == OP_WR_EN && !np.ok && !err_pop_i &&
      q.eq_cnt != QCNT_FULL |=>
      q.eq_cnt == SES_QCW'($past(q.eq_cnt) + QCNT_ONE))
    else $error("refused write left no error entry");

  a_fmt_used: assert property (
    cmd_vld_i && cmd_op_i == OP_QUERY |=> rsp_fmt_o == $past(q.fmt))
    else $error("answer format not the selected one");

  c_srq_raised: cover property (!srq_o ##1 srq_o);
  c_poll_req:   cover property (spoll_i && q.request_for_service_flag);
  c_fmt_hex:    cover property (rsp_vld_o && rsp_fmt_o == FMT_HEX);
  c_evt_query:  cover property (
    cmd_vld_i && cmd_op_i == OP_QUERY && cmd_reg_i == REG_EVT &&
    sel_evt != '0);
  c_wr_refused: cover property (wr_err_o);
endmodule : status_event_summary

/* File: ses_ctrl_model.sv */
// controller-side model: issues commands, parameter strings and pulses
`timescale 1ns/1ns
module ses_ctrl_model (
  input  wire logic         clk_sys_i,  // system clock
  output logic              cmd_vld_o,  // command strobe
  output ses_pkg::ses_op_t  cmd_op_o,   // command code
  output ses_pkg::ses_reg_t cmd_reg_o,  // register kind
  output logic [1:0]        cmd_set_o,  // register set
  output ses_pkg::ses_fmt_t cmd_fmt_o,  // readback format
  output logic              par_clr_o,  // new parameter
  output logic              par_vld_o,  // parameter char
  output logic [7:0]        par_chr_o,  // ascii character
  output logic              push_o,     // error message
  output logic              epop_o,     // error read out
  output logic              opop_o,     // response taken
  output logic              poll_o      // serial poll
);
  import ses_pkg::*;
  logic [3:0] pls = 4'h0;
  // one-cycle pulses share one vector so a single task drives them all
  assign {poll_o, opop_o, epop_o, push_o} = pls;
  initial begin
    cmd_vld_o = 1'b0;
    cmd_op_o  = OP_CLS;
    cmd_reg_o = REG_COND;
    cmd_set_o = 2'h0;
    cmd_fmt_o = FMT_ASC;
    {par_clr_o, par_vld_o, par_chr_o} = '0;
  end
  // one command, held over exactly one taking edge
  task automatic cmd(input ses_op_t op, input ses_reg_t rg,
                     input logic [1:0] st, input ses_fmt_t f);
    @(posedge clk_sys_i);
    #1;
    cmd_op_o  = op;
    cmd_reg_o = rg;
    cmd_set_o = st;
    cmd_fmt_o = f;
    cmd_vld_o = 1'b1;
    @(posedge clk_sys_i);
    #1;
    cmd_vld_o = 1'b0;
  endtask : cmd
  // clear, then characters most significant first, one per cycle
  task automatic param(input string s);
    @(posedge clk_sys_i);
    #1;
    par_clr_o = 1'b1;
    for (int i = 0; i < s.len(); i++) begin
      @(posedge clk_sys_i);
      #1;
      par_clr_o = 1'b0;
      par_vld_o = 1'b1;
      par_chr_o = s[i];
    end
    @(posedge clk_sys_i);
    #1;
    par_vld_o = 1'b0;
  endtask : param
  // k: 0 error push, 1 error pop, 2 output pop, 3 serial poll
  task automatic pulse(input int k);
    @(posedge clk_sys_i);
    #1;
    pls[k] = 1'b1;
    @(posedge clk_sys_i);
    #1;
    pls[k] = 1'b0;
  endtask : pulse
endmodule : ses_ctrl_model

/* File: status_event_summary_tb.sv */
// self-checking bench for the status event summary block
`timescale 1ns/1ns
module status_event_summary_tb;
  import ses_pkg::*;
  logic                           clk_sys_i = 1'b0;
  logic                           rst_n_i = 1'b0;
  logic [SES_NSET-1:0][SES_W-1:0] cond_i = '0;
  logic [SES_NSET-1:0][SES_W-1:0] evt_i = '0;
  logic       cmd_vld_i, par_clr_i, par_vld_i, err_push_i, err_pop_i;
  logic       oq_pop_i, spoll_i, spoll_vld_o, srq_o, rsp_vld_o, wr_err_o;
  ses_op_t    cmd_op_i;
  ses_reg_t   cmd_reg_i;
  ses_fmt_t   cmd_fmt_i, rsp_fmt_o;
  logic [1:0] cmd_set_i;
  logic [7:0] par_chr_i, stb_o, spoll_o, rsp_hdr_o;
  logic [15:0] rsp_val_o;
  int miscompares = 0;
  int checked = 0;
  string       vals[4] = '{"#q54", "#h2C", "26", "#B11010"};
  logic [15:0] vexp[4] = '{16'h002C, 16'h002C, 16'h001A, 16'h001A};
  ses_fmt_t    fmts[3] = '{FMT_HEX, FMT_OCT, FMT_BIN};
  logic [7:0]  hdrs[3] = '{HDR_H, HDR_Q, HDR_B};
  ses_op_t     clrs[2] = '{OP_QUE_CLR, OP_ERR_CLR};
  always #5 clk_sys_i = ~clk_sys_i;
  status_event_summary u_dut (.clk_sys_i, .rst_n_i, .cond_i, .evt_i,
    .cmd_vld_i, .cmd_op_i, .cmd_reg_i, .cmd_set_i, .cmd_fmt_i, .par_clr_i,
    .par_vld_i, .par_chr_i, .err_push_i, .err_pop_i, .oq_pop_i, .spoll_i,
    .stb_o, .spoll_o, .spoll_vld_o, .srq_o, .rsp_vld_o, .rsp_val_o,
    .rsp_hdr_o, .rsp_fmt_o, .wr_err_o);
  ses_ctrl_model u_ctrl (.clk_sys_i, .cmd_vld_o(cmd_vld_i),
    .cmd_op_o(cmd_op_i), .cmd_reg_o(cmd_reg_i), .cmd_set_o(cmd_set_i),
    .cmd_fmt_o(cmd_fmt_i), .par_clr_o(par_clr_i), .par_vld_o(par_vld_i),
    .par_chr_o(par_chr_i), .push_o(err_push_i), .epop_o(err_pop_i),
    .opop_o(oq_pop_i), .poll_o(spoll_i));
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic end_of_test;
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : end_of_test
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys_i);
    #1;
  endtask : tick
  task automatic wr(input string s, input ses_reg_t rg, input logic [1:0] st,
                    input logic e);
    u_ctrl.param(s);
    u_ctrl.cmd(OP_WR_EN, rg, st, FMT_ASC);
    chk(wr_err_o, e);
  endtask : wr
  // query, check answer, then take the response out of the output queue
  task automatic qry(input ses_reg_t rg, input logic [1:0] st,
                     input logic [15:0] e);
    u_ctrl.cmd(OP_QUERY, rg, st, FMT_ASC);
    chk(rsp_vld_o, 1'b1);
    chk(rsp_val_o, e);
    chk(stb_o[SB_MAV], 1'b1);
    u_ctrl.pulse(2);
  endtask : qry
  // one-cycle event, then settle time for summary and request flag
  task automatic evt(input logic [1:0] st, input int b);
    @(posedge clk_sys_i);
    #1;
    evt_i[st][b] = 1'b1;
    tick(1);
    evt_i[st][b] = 1'b0;
    tick(2);
  endtask : evt
  initial begin
    #50000;
    miscompares++;
    end_of_test();
  end
  initial begin
    tick(4);
    rst_n_i = 1'b1;
    chk(stb_o, 8'h00);
    qry(REG_EN, SET_OPER, 16'h0000);
    chk(rsp_fmt_o, FMT_ASC);
    chk(rsp_hdr_o, HDR_NONE);
    tick(1);
    chk(stb_o[SB_MAV], 1'b0);
    for (int i = 0; i < 4; i++) begin
      wr(vals[i], REG_EN, 2'(i), 1'b0);
      qry(REG_EN, 2'(i), vexp[i]);
    end
    wr("#b102", REG_EN, SET_OPER, 1'b1);
    wr("5", REG_COND, SET_OPER, 1'b1);
    wr("5", REG_EVT, SET_OPER, 1'b1);
    wr("5", REG_STB, SET_OPER, 1'b1);
    qry(REG_EN, SET_OPER, 16'h002C);
    tick(1);
    chk(stb_o[SB_ERRQ], 1'b1);
    evt(SET_OPER, 5);
    chk(stb_o[SB_OPER], 1'b1);
    tick(5);
    chk(stb_o[SB_OPER], 1'b1);
    qry(REG_EVT, SET_OPER, 16'h0020);
    tick(1);
    chk(stb_o[SB_OPER], 1'b0);
    wr("128", REG_SRE, 2'h0, 1'b0);
    chk(srq_o, 1'b0);
    qry(REG_SRE, 2'h0, 16'h0080);
    evt(SET_OPER, 5);
    tick(1);
    chk(stb_o[SB_MASTER], 1'b1);
    chk(srq_o, 1'b1);
    u_ctrl.pulse(3);
    chk(spoll_vld_o, 1'b1);
    chk(spoll_o[SB_MASTER], 1'b1);
    tick(1);
    chk(srq_o, 1'b0);
    chk(stb_o, 8'hC4);
    qry(REG_STB, 2'h0, 16'h00C4);
    // second poll: request flag gone, master summary still set
    u_ctrl.pulse(3);
    chk(spoll_o, 8'h84);
    cond_i[SET_MEAS] = 16'hA5C3;
    for (int i = 0; i < 3; i++) begin
      u_ctrl.cmd(OP_FMT, REG_COND, 2'h0, fmts[i]);
      qry(REG_COND, SET_MEAS, 16'hA5C3);
      chk(rsp_hdr_o, hdrs[i]);
      chk(rsp_fmt_o, fmts[i]);
    end
    cond_i[SET_MEAS] = 16'h0F0F;
    tick(1);
    qry(REG_COND, SET_MEAS, 16'h0F0F);
    u_ctrl.cmd(OP_SYS_PRE, REG_COND, 2'h0, FMT_ASC);
    u_ctrl.cmd(OP_RST, REG_COND, 2'h0, FMT_ASC);
    tick(1);
    chk(stb_o, 8'hC4);
    u_ctrl.cmd(OP_STAT_PRE, REG_COND, 2'h0, FMT_ASC);
    tick(1);
    chk(stb_o[SB_ERRQ], 1'b1);
    qry(REG_EN, SET_STD, 16'h002C);
    evt(SET_STD, 2);
    chk(stb_o[SB_STD], 1'b1);
    u_ctrl.cmd(OP_CLS, REG_COND, 2'h0, FMT_ASC);
    tick(1);
    chk(stb_o[SB_STD], 1'b0);
    chk(stb_o[SB_ERRQ], 1'b0);
    qry(REG_EN, SET_MEAS, 16'h0000);
    qry(REG_EN, SET_STD, 16'h002C);
    for (int i = 0; i < 2; i++) begin
      u_ctrl.pulse(0);
      tick(1);
      chk(stb_o[SB_ERRQ], 1'b1);
      u_ctrl.cmd(clrs[i], REG_COND, 2'h0, FMT_ASC);
      tick(1);
      chk(stb_o[SB_ERRQ], 1'b0);
    end
    u_ctrl.pulse(0);
    u_ctrl.pulse(1);
    tick(1);
    chk(stb_o[SB_ERRQ], 1'b0);
    wr("0", REG_EN, SET_STD, 1'b0);
    qry(REG_EN, SET_STD, 16'h0000);
    end_of_test();
  end
endmodule : status_event_summary_tb
